/* logic/cmc_div.v */
// Power-of-two tick divider used for the clock gear and the prescaler.
`default_nettype none

module cmc_div #(
  parameter CW = 7
) (
  input wire CLK,
  input wire RST_N,
  input wire tick_in,
  input wire [2:0] sel,
  output reg tick_out
);

  reg [CW-1:0] cnt_r;
  reg [2:0] sel_r;
  wire [CW-1:0] term;

  // Terminal count for the divide ratio now in force.
  assign term = ~({CW{1'b1}} << sel_r);

  // A new ratio is only taken at the wrap, so no shortened period can appear.
  always @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      cnt_r <= {CW{1'b0}};
      sel_r <= 3'h0;
      tick_out <= 1'b0;
    end else begin
      tick_out <= 1'b0;
      if (tick_in) begin
        if ((cnt_r & term) == term) begin
          cnt_r <= {CW{1'b0}};
          sel_r <= sel;
          tick_out <= 1'b1;
        end else begin
          cnt_r <= cnt_r + 1'b1;
        end
      end
    end
  end

endmodule

`default_nettype wire

/* logic/cmc_map.vh */
// Register map, field positions and reset values of the clock mode controller.
// Contract
// - Reset runs every clock from internal oscillator, undivided.
// - Reset: internal oscillator on, external oscillator off.
// - PLL output is four or five times oscillator.
// - PLL off at reset; power bit, then select.
// - Warm-up source: first bit zero, second picks.
// - Twelve-bit field sets warm-up cycle count.
// - Enable bit starts warm-up; flag zero when done.
// - STOP wake starts warm-up; CPU resumes after.
// - Gear divides by 1,2,4,8,16; reset 1.
// - Oscillator pins enabled: port M reads zero.
// - Pin enable refused if port M control changed.
// - External switch sequence ends reading bit 17.
// - Prescaler input is peripheral source divided.
`ifndef CMC_MAP_VH
`define CMC_MAP_VH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define CMC_ADDR_SYS_CTRL 8'h00
`define CMC_ADDR_OSC_CTRL 8'h04
`define CMC_ADDR_PLL_SEL 8'h08
`define CMC_ADDR_PM_DATA 8'h10
`define CMC_ADDR_PM_OPENDRAIN 8'h14
`define CMC_ADDR_PM_CTRL 8'h18

// ----------------------------------------------------------------
// System control fields
// ----------------------------------------------------------------
`define CMC_SYS_GEAR_LSB 0
`define CMC_SYS_PRESC_LSB 8
`define CMC_SYS_PSRC_BIT 12
`define CMC_GEAR_MAX 3'h4

// ----------------------------------------------------------------
// Oscillation control fields
// ----------------------------------------------------------------
`define CMC_OSC_WUSTART_BIT 0
`define CMC_OSC_WUBUSY_BIT 1
`define CMC_OSC_PLLPWR_BIT 2
`define CMC_OSC_WUSRCA_BIT 8
`define CMC_OSC_WUSRCB_BIT 9
`define CMC_OSC_PINEN_BIT 12
`define CMC_OSC_XEXT_BIT 16
`define CMC_OSC_SYSSEL_BIT 17
`define CMC_OSC_XINT_BIT 18
`define CMC_OSC_WUCNT_LSB 20

// ----------------------------------------------------------------
// PLL selection fields and multipliers
// ----------------------------------------------------------------
`define CMC_PLL_OUTSEL_BIT 0
`define CMC_PLL_MULT_BIT 1
`define CMC_PLL_MULT_LO 3'h4
`define CMC_PLL_MULT_HI 3'h5

// ----------------------------------------------------------------
// Reset values and timing
// ----------------------------------------------------------------
`define CMC_PM_CTRL_RESET 8'h00
`define CMC_WU_FRAC_BITS 4

`endif

/* logic/cmc_top.v */
// Clock mode controller: source select, PLL, gear, prescaler, warm-up and STOP.
//
// The placing of the registers and strobed register access were left to the implementer.
`default_nettype none
`include "cmc_map.vh"

module cmc_top #(
  parameter AW = 8,
  parameter PMW = 8
) (
  input wire CLK,
  input wire RST_N,
  input wire [AW-1:0] ADDR,
  input wire [31:0] WDATA,
  input wire WR,
  input wire RD,
  output reg [31:0] RDATA,
  input wire INT_OSC_TICK,
  input wire EXT_OSC_TICK,
  input wire STOP_REQ,
  input wire WAKE_IRQ,
  output reg INT_OSC_ON,
  output reg EXT_OSC_ON,
  output reg OSC_PIN_MODE,
  output reg PLL_ON,
  output reg HS_CLK_EN,
  output reg SYS_CLK_EN,
  output wire PRESC_CLK_EN,
  output reg CPU_RUN,
  output reg [PMW-1:0] PM_DATA_OUT,
  output reg [PMW-1:0] PM_OD_OUT,
  output reg [PMW-1:0] PM_CTRL_OUT
);

  // ----------------------------------------------------------------
  // Mode states
  // ----------------------------------------------------------------
  localparam ST_RUN = 3'b001;
  localparam ST_STOP = 3'b010;
  localparam ST_WARM = 3'b100;

  // ----------------------------------------------------------------
  // Software visible state
  // ----------------------------------------------------------------
  reg [2:0] gear_r, presc_div_r;
  reg periph_source_select_r, pll_power_on_r, warmup_src_sel_a_r, warmup_src_sel_b_r;
  reg osc_pin_enable_r, external_osc_enable_r, system_osc_select_r, internal_osc_enable_r;
  reg [11:0] warmup_count_value_r;
  reg pll_output_select_r, pll_mult_r;
  reg [PMW-1:0] pm_data_r, pm_od_r, pm_ctrl_r;

  // ----------------------------------------------------------------
  // Internal clock state
  // ----------------------------------------------------------------
  reg [2:0] state_r, state_nxt, burst_r;
  reg int_run_r, ext_run_r, pll_run_r, pll_tick_r;
  reg osc_sel_eff_r, pll_path_eff_r, hs_tick_r;
  reg [31:0] rd_nxt;

  wire int_tick, ext_tick, osc_tick, wu_tick, quiet;
  wire gear_tick, periph_tick, wu_busy, wu_start, sw_start, stop_go;
  wire wr_sys, wr_osc, wr_pll, wr_pm;
  wire [2:0] mult;

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  // Register write selects.
  assign wr_sys = WR && (ADDR == `CMC_ADDR_SYS_CTRL);
  assign wr_osc = WR && (ADDR == `CMC_ADDR_OSC_CTRL);
  assign wr_pll = WR && (ADDR == `CMC_ADDR_PLL_SEL);
  assign wr_pm = WR && !osc_pin_enable_r;

  // The manual start is a pulse; it never stays stored.
  assign sw_start = wr_osc && WDATA[`CMC_OSC_WUSTART_BIT];

  // ----------------------------------------------------------------
  // Oscillator ticks
  // ----------------------------------------------------------------
  // Ticks only pass while the oscillator is enabled and not stopped.
  assign int_tick = INT_OSC_TICK && int_run_r;
  assign ext_tick = EXT_OSC_TICK && ext_run_r;
  assign osc_tick = osc_sel_eff_r ? ext_tick : int_tick;

  // The first select bit is stored but does not steer the source.
  assign wu_tick = warmup_src_sel_b_r ? ext_tick : int_tick;

  // Path switches wait for a cycle with no tick in flight anywhere.
  assign quiet = !INT_OSC_TICK && !EXT_OSC_TICK && (burst_r == 3'h0) && !pll_tick_r;

  assign mult = pll_mult_r ? `CMC_PLL_MULT_HI : `CMC_PLL_MULT_LO;

  // ----------------------------------------------------------------
  // Software registers
  // ----------------------------------------------------------------
  // Reset leaves the internal oscillator alone in charge, undivided.
  always @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      gear_r <= 3'h0;
      presc_div_r <= 3'h0;
      periph_source_select_r <= 1'b0;
      pll_power_on_r <= 1'b0;
      warmup_src_sel_a_r <= 1'b0;
      warmup_src_sel_b_r <= 1'b0;
      osc_pin_enable_r <= 1'b0;
      external_osc_enable_r <= 1'b0;
      system_osc_select_r <= 1'b0;
      internal_osc_enable_r <= 1'b1;
      warmup_count_value_r <= 12'h000;
      pll_output_select_r <= 1'b0;
      pll_mult_r <= 1'b0;
    end else begin
      if (wr_sys) begin
        // Reserved gear codes are dropped so the divider never sees them.
        if (WDATA[`CMC_SYS_GEAR_LSB+2:`CMC_SYS_GEAR_LSB] <= `CMC_GEAR_MAX) begin
          gear_r <= WDATA[`CMC_SYS_GEAR_LSB+2:`CMC_SYS_GEAR_LSB];
        end
        presc_div_r <= WDATA[`CMC_SYS_PRESC_LSB+2:`CMC_SYS_PRESC_LSB];
        periph_source_select_r <= WDATA[`CMC_SYS_PSRC_BIT];
      end
      if (wr_osc) begin
        pll_power_on_r <= WDATA[`CMC_OSC_PLLPWR_BIT];
        warmup_src_sel_a_r <= WDATA[`CMC_OSC_WUSRCA_BIT];
        warmup_src_sel_b_r <= WDATA[`CMC_OSC_WUSRCB_BIT];
        external_osc_enable_r <= WDATA[`CMC_OSC_XEXT_BIT];
        system_osc_select_r <= WDATA[`CMC_OSC_SYSSEL_BIT];
        internal_osc_enable_r <= WDATA[`CMC_OSC_XINT_BIT];
        warmup_count_value_r <= WDATA[`CMC_OSC_WUCNT_LSB+11:`CMC_OSC_WUCNT_LSB];
        // Setting is refused while port M control is away from reset.
        if (!WDATA[`CMC_OSC_PINEN_BIT]) begin
          osc_pin_enable_r <= 1'b0;
        end else if (pm_ctrl_r == `CMC_PM_CTRL_RESET) begin
          osc_pin_enable_r <= 1'b1;
        end
      end
      if (wr_pll) begin
        pll_output_select_r <= WDATA[`CMC_PLL_OUTSEL_BIT];
        pll_mult_r <= WDATA[`CMC_PLL_MULT_BIT];
      end
    end
  end

  // ----------------------------------------------------------------
  // Port M registers
  // ----------------------------------------------------------------
  // Writes are ignored while the pins serve the crystal.
  always @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      pm_data_r <= {PMW{1'b0}};
      pm_od_r <= {PMW{1'b0}};
      pm_ctrl_r <= `CMC_PM_CTRL_RESET;
    end else if (wr_pm) begin
      if (ADDR == `CMC_ADDR_PM_DATA) begin
        pm_data_r <= WDATA[PMW-1:0];
      end
      if (ADDR == `CMC_ADDR_PM_OPENDRAIN) begin
        pm_od_r <= WDATA[PMW-1:0];
      end
      if (ADDR == `CMC_ADDR_PM_CTRL) begin
        pm_ctrl_r <= WDATA[PMW-1:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  // Read mux; the selection bit reads the source actually in use.
  always @* begin
    rd_nxt = 32'h00000000;
    case (ADDR)
      `CMC_ADDR_SYS_CTRL: begin
        rd_nxt[`CMC_SYS_GEAR_LSB+2:`CMC_SYS_GEAR_LSB] = gear_r;
        rd_nxt[`CMC_SYS_PRESC_LSB+2:`CMC_SYS_PRESC_LSB] = presc_div_r;
        rd_nxt[`CMC_SYS_PSRC_BIT] = periph_source_select_r;
      end
      `CMC_ADDR_OSC_CTRL: begin
        rd_nxt[`CMC_OSC_WUBUSY_BIT] = wu_busy;
        rd_nxt[`CMC_OSC_PLLPWR_BIT] = pll_power_on_r;
        rd_nxt[`CMC_OSC_WUSRCA_BIT] = warmup_src_sel_a_r;
        rd_nxt[`CMC_OSC_WUSRCB_BIT] = warmup_src_sel_b_r;
        rd_nxt[`CMC_OSC_PINEN_BIT] = osc_pin_enable_r;
        rd_nxt[`CMC_OSC_XEXT_BIT] = external_osc_enable_r;
        rd_nxt[`CMC_OSC_SYSSEL_BIT] = osc_sel_eff_r;
        rd_nxt[`CMC_OSC_XINT_BIT] = internal_osc_enable_r;
        rd_nxt[`CMC_OSC_WUCNT_LSB+11:`CMC_OSC_WUCNT_LSB] = warmup_count_value_r;
      end
      `CMC_ADDR_PLL_SEL: begin
        rd_nxt[`CMC_PLL_OUTSEL_BIT] = pll_output_select_r;
        rd_nxt[`CMC_PLL_MULT_BIT] = pll_mult_r;
      end
      `CMC_ADDR_PM_DATA: begin
        if (!osc_pin_enable_r) begin
          rd_nxt[PMW-1:0] = pm_data_r;
        end
      end
      `CMC_ADDR_PM_OPENDRAIN: begin
        if (!osc_pin_enable_r) begin
          rd_nxt[PMW-1:0] = pm_od_r;
        end
      end
      `CMC_ADDR_PM_CTRL: begin
        if (!osc_pin_enable_r) begin
          rd_nxt[PMW-1:0] = pm_ctrl_r;
        end
      end
      default: begin
        rd_nxt = 32'h00000000;
      end
    endcase
  end

  // Read data stand for one cycle only and are zero otherwise.
  always @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      RDATA <= 32'h00000000;
    end else begin
      RDATA <= RD ? rd_nxt : 32'h00000000;
    end
  end

  // ----------------------------------------------------------------
  // Mode sequencing
  // ----------------------------------------------------------------
  // A STOP request during a warm-up is ignored rather than cutting it short.
  assign stop_go = STOP_REQ && !wu_busy && !sw_start;

  // The wake interrupt restarts the warm-up without software help.
  assign wu_start = sw_start || (state_r == ST_STOP && WAKE_IRQ);

  // Next mode.
  always @* begin
    state_nxt = state_r;
    case (state_r)
      ST_RUN: begin
        if (stop_go) begin
          state_nxt = ST_STOP;
        end
      end
      ST_STOP: begin
        if (WAKE_IRQ) begin
          state_nxt = ST_WARM;
        end
      end
      ST_WARM: begin
        if (!wu_busy) begin
          state_nxt = ST_RUN;
        end
      end
      default: begin
        state_nxt = ST_RUN;
      end
    endcase
  end

  // Mode register and the run enables derived from it.
  always @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      state_r <= ST_RUN;
      CPU_RUN <= 1'b1;
      int_run_r <= 1'b1;
      ext_run_r <= 1'b0;
      pll_run_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      CPU_RUN <= (state_nxt == ST_RUN);
      int_run_r <= internal_osc_enable_r && (state_nxt != ST_STOP);
      ext_run_r <= external_osc_enable_r && osc_pin_enable_r && (state_nxt != ST_STOP);
      // The PLL drops out for the whole of STOP and restarts on wake.
      pll_run_r <= pll_power_on_r && (state_nxt != ST_STOP);
    end
  end

  // ----------------------------------------------------------------
  // PLL and high-speed clock
  // ----------------------------------------------------------------
  // Each oscillator tick opens a burst of four or five output ticks.
  // A burst still running when the next tick arrives is cut short, so the
  // oscillator period must be at least five system clock cycles.
  always @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      burst_r <= 3'h0;
      pll_tick_r <= 1'b0;
      osc_sel_eff_r <= 1'b0;
      pll_path_eff_r <= 1'b0;
      hs_tick_r <= 1'b0;
    end else begin
      pll_tick_r <= (burst_r != 3'h0);
      if (osc_tick && pll_run_r) begin
        burst_r <= mult;
      end else if (burst_r != 3'h0) begin
        burst_r <= burst_r - 3'h1;
      end
      if (quiet) begin
        osc_sel_eff_r <= system_osc_select_r;
        pll_path_eff_r <= pll_output_select_r && pll_run_r;
      end
      hs_tick_r <= pll_path_eff_r ? pll_tick_r : osc_tick;
    end
  end

  // ----------------------------------------------------------------
  // Gear, prescaler and warm-up
  // ----------------------------------------------------------------
  cmc_div #(
    .CW(4)
  ) u_gear (
    .CLK(CLK),
    .RST_N(RST_N),
    .tick_in(hs_tick_r),
    .sel(gear_r),
    .tick_out(gear_tick)
  );

  // Peripheral source is the geared clock or the undivided high-speed one.
  assign periph_tick = periph_source_select_r ? hs_tick_r : gear_tick;

  cmc_div #(
    .CW(7)
  ) u_presc (
    .CLK(CLK),
    .RST_N(RST_N),
    .tick_in(periph_tick),
    .sel(presc_div_r),
    .tick_out(PRESC_CLK_EN)
  );

  cmc_warmup #(
    .FW(12)
  ) u_warmup (
    .CLK(CLK),
    .RST_N(RST_N),
    .start(wu_start),
    .tick(wu_tick),
    .count(warmup_count_value_r),
    .busy(wu_busy)
  );

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // System clock is held back until the mode is back in RUN.
  always @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      HS_CLK_EN <= 1'b0;
      SYS_CLK_EN <= 1'b0;
      INT_OSC_ON <= 1'b1;
      EXT_OSC_ON <= 1'b0;
      OSC_PIN_MODE <= 1'b0;
      PLL_ON <= 1'b0;
      PM_DATA_OUT <= {PMW{1'b0}};
      PM_OD_OUT <= {PMW{1'b0}};
      PM_CTRL_OUT <= `CMC_PM_CTRL_RESET;
    end else begin
      HS_CLK_EN <= hs_tick_r;
      SYS_CLK_EN <= gear_tick && (state_r == ST_RUN);
      INT_OSC_ON <= int_run_r;
      EXT_OSC_ON <= ext_run_r;
      OSC_PIN_MODE <= osc_pin_enable_r;
      PLL_ON <= pll_run_r;
      PM_DATA_OUT <= pm_data_r;
      PM_OD_OUT <= pm_od_r;
      PM_CTRL_OUT <= pm_ctrl_r;
    end
  end

endmodule

`default_nettype wire

/* logic/cmc_warmup.v */
// Warm-up timer counting oscillator ticks in units of sixteen.
`default_nettype none
`include "cmc_map.vh"

module cmc_warmup #(
  parameter FW = 12
) (
  input wire CLK,
  input wire RST_N,
  input wire start,
  input wire tick,
  input wire [FW-1:0] count,
  output reg busy
);

  reg [FW+`CMC_WU_FRAC_BITS-1:0] cnt_r;

  // The low bits form the sixteen-cycle unit, so only the upper bits meet the field.
  always @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      cnt_r <= {(FW+`CMC_WU_FRAC_BITS){1'b0}};
      busy <= 1'b0;
    end else if (start) begin
      cnt_r <= {(FW+`CMC_WU_FRAC_BITS){1'b0}};
      busy <= 1'b1;
    end else if (busy) begin
      if (cnt_r[FW+`CMC_WU_FRAC_BITS-1:`CMC_WU_FRAC_BITS] >= count) begin
        busy <= 1'b0;
      end else if (tick) begin
        cnt_r <= cnt_r + 1'b1;
      end
    end
  end

endmodule

`default_nettype wire

/* sim/cmc_checker.sv */
// Port-level assertions for the clock mode controller.
`default_nettype none
`include "cmc_map.vh"

module cmc_checker #(
  parameter AW = 8,
  parameter PMW = 8
) (
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic [AW-1:0] ADDR,
  input wire logic [31:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  input wire logic [31:0] RDATA,
  input wire logic INT_OSC_TICK,
  input wire logic EXT_OSC_TICK,
  input wire logic STOP_REQ,
  input wire logic WAKE_IRQ,
  input wire logic INT_OSC_ON,
  input wire logic EXT_OSC_ON,
  input wire logic OSC_PIN_MODE,
  input wire logic PLL_ON,
  input wire logic HS_CLK_EN,
  input wire logic SYS_CLK_EN,
  input wire logic PRESC_CLK_EN,
  input wire logic CPU_RUN,
  input wire logic [PMW-1:0] PM_DATA_OUT,
  input wire logic [PMW-1:0] PM_OD_OUT,
  input wire logic [PMW-1:0] PM_CTRL_OUT
);
  timeunit 1ns;
  timeprecision 1ps;
  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_N);
  // Decoded port M window, so hidden reads can be tied to their address.
  wire logic pm_hit = (ADDR == `CMC_ADDR_PM_DATA) || (ADDR == `CMC_ADDR_PM_OPENDRAIN) || (ADDR == `CMC_ADDR_PM_CTRL);
  a_reset_state: assert property ($rose(RST_N) |-> INT_OSC_ON && CPU_RUN && !EXT_OSC_ON && !PLL_ON)
    else $error("clock state wrong after reset");
  a_ext_needs_pins: assert property (EXT_OSC_ON |-> OSC_PIN_MODE || $past(OSC_PIN_MODE))
    else $error("crystal running without its pins");
  a_portm_hidden: assert property ($past(RD) && OSC_PIN_MODE && $past(pm_hit) |-> RDATA == 32'h0)
    else $error("port M readable while pins belong to crystal");
  a_portm_frozen: assert property (OSC_PIN_MODE |=> $stable(PM_DATA_OUT) && $stable(PM_OD_OUT) && $stable(PM_CTRL_OUT))
    else $error("port M changed while pins belong to crystal");
  a_pin_refused: assert property ($rose(OSC_PIN_MODE) |-> $past(PM_CTRL_OUT) == {PMW{1'b0}})
    else $error("pin enable taken with port M control altered");
  a_stop_osc_off: assert property ($fell(CPU_RUN) |-> ##[1:2] (!INT_OSC_ON && !EXT_OSC_ON && !PLL_ON))
    else $error("oscillator or PLL left on in stop");
  a_stop_no_sys: assert property (!CPU_RUN [*3] |-> !SYS_CLK_EN)
    else $error("system clock running while halted");
  a_wake_warm: assert property ($rose(CPU_RUN) |-> $past(INT_OSC_ON, 2) || $past(EXT_OSC_ON, 2))
    else $error("resume without a running oscillator");
  a_wake_delayed: assert property (!CPU_RUN && WAKE_IRQ |=> !CPU_RUN)
    else $error("resume without warm-up");
  c_pin_mode: cover property ($rose(OSC_PIN_MODE));
  c_resume: cover property ($rose(CPU_RUN));
  c_pll_tick: cover property (PLL_ON && HS_CLK_EN);
endmodule

bind cmc_top cmc_checker #(.AW(AW), .PMW(PMW)) u_cmc_checker (
  .CLK(CLK), .RST_N(RST_N), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA),
  .INT_OSC_TICK(INT_OSC_TICK), .EXT_OSC_TICK(EXT_OSC_TICK), .STOP_REQ(STOP_REQ), .WAKE_IRQ(WAKE_IRQ),
  .INT_OSC_ON(INT_OSC_ON), .EXT_OSC_ON(EXT_OSC_ON), .OSC_PIN_MODE(OSC_PIN_MODE), .PLL_ON(PLL_ON),
  .HS_CLK_EN(HS_CLK_EN), .SYS_CLK_EN(SYS_CLK_EN), .PRESC_CLK_EN(PRESC_CLK_EN), .CPU_RUN(CPU_RUN),
  .PM_DATA_OUT(PM_DATA_OUT), .PM_OD_OUT(PM_OD_OUT), .PM_CTRL_OUT(PM_CTRL_OUT)
);
`default_nettype wire

/* sim/cmc_osc_model.sv */
// Behavioural oscillator giving one tick per period while powered.
`default_nettype none

module cmc_osc_model (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic run,
  input wire logic [7:0] period,
  output var logic tick
);
  timeunit 1ns;
  timeprecision 1ps;
  // ------------------------------------------------------------
  // Tick generator
  // ------------------------------------------------------------
  logic [7:0] cnt_r;
  // An unpowered oscillator gives no ticks at all, so a design that counts them anyway is caught.
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r <= 8'h00;
      tick <= 1'b0;
    end else if (!run) begin
      cnt_r <= 8'h00;
      tick <= 1'b0;
    end else begin
      cnt_r <= (cnt_r + 8'h01 >= period) ? 8'h00 : cnt_r + 8'h01;
      tick <= (cnt_r + 8'h01 >= period);
    end
  end
endmodule
`default_nettype wire

/* sim/test_clock_mode_control.sv */
// Self-checking testbench of the clock mode controller.
`default_nettype none

module test_clock_mode_control;
  timeunit 1ns;
  timeprecision 1ps;
  // ------------------------------------------------------------
  // Stimulus, tasks and tests
  // ------------------------------------------------------------
  logic CLK = 1'b0;
  logic RST_N = 1'b0;
  logic WR = 1'b0;
  logic RD = 1'b0;
  logic STOP_REQ = 1'b0;
  logic WAKE_IRQ = 1'b0;
  logic [7:0] ADDR = 8'h00;
  logic [31:0] WDATA = 32'h0;
  logic [31:0] RDATA, rv;
  logic INT_OSC_TICK, EXT_OSC_TICK, INT_OSC_ON, EXT_OSC_ON, OSC_PIN_MODE, PLL_ON;
  logic HS_CLK_EN, SYS_CLK_EN, PRESC_CLK_EN, CPU_RUN;
  logic [7:0] PM_DATA_OUT, PM_OD_OUT, PM_CTRL_OUT;
  int n_errors = 0;
  int n_checks = 0;
  int n_hs = 0;
  int n_sys = 0;
  int n_pre = 0;
  int el;
  time t0;

  always #12.5 CLK = ~CLK;

  // Pulse counters read the pre-edge values, so they never race the design's updates.
  always @(posedge CLK) begin
    n_hs += HS_CLK_EN;
    n_sys += SYS_CLK_EN;
    n_pre += PRESC_CLK_EN;
  end

  cmc_osc_model u_int_osc (.clk(CLK), .rst_n(RST_N), .run(INT_OSC_ON), .period(8'h08), .tick(INT_OSC_TICK));
  cmc_osc_model u_ext_osc (.clk(CLK), .rst_n(RST_N), .run(EXT_OSC_ON), .period(8'h0A), .tick(EXT_OSC_TICK));

  cmc_top u_cmc_top (
    .CLK(CLK), .RST_N(RST_N), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA),
    .INT_OSC_TICK(INT_OSC_TICK), .EXT_OSC_TICK(EXT_OSC_TICK), .STOP_REQ(STOP_REQ), .WAKE_IRQ(WAKE_IRQ),
    .INT_OSC_ON(INT_OSC_ON), .EXT_OSC_ON(EXT_OSC_ON), .OSC_PIN_MODE(OSC_PIN_MODE), .PLL_ON(PLL_ON),
    .HS_CLK_EN(HS_CLK_EN), .SYS_CLK_EN(SYS_CLK_EN), .PRESC_CLK_EN(PRESC_CLK_EN), .CPU_RUN(CPU_RUN),
    .PM_DATA_OUT(PM_DATA_OUT), .PM_OD_OUT(PM_OD_OUT), .PM_CTRL_OUT(PM_CTRL_OUT)
  );

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge CLK);
    ADDR <= a;
    WDATA <= d;
    WR <= 1'b1;
    @(posedge CLK);
    WR <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge CLK);
    ADDR <= a;
    RD <= 1'b1;
    @(posedge CLK);
    RD <= 1'b0;
    #1;
    d = RDATA;
  endtask

  // Lets a new setting settle past a divider wrap, then counts pulses over a whole number of periods.
  task automatic meas(input int win, input int hs, input int sys, input int pre);
    int h, s, p;
    repeat (200) @(posedge CLK);
    #1;
    h = n_hs;
    s = n_sys;
    p = n_pre;
    repeat (win) @(posedge CLK);
    #1;
    chk(32'(n_hs - h), 32'(hs));
    chk(32'(n_sys - s), 32'(sys));
    chk(32'(n_pre - p), 32'(pre));
  endtask

  task automatic pulse_stop_or_wake(input logic wake);
    @(posedge CLK);
    if (wake) begin
      WAKE_IRQ <= 1'b1;
    end else begin
      STOP_REQ <= 1'b1;
    end
    @(posedge CLK);
    WAKE_IRQ <= 1'b0;
    STOP_REQ <= 1'b0;
  endtask

  task automatic print_verdict;
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // A hang in any handshake is cut short well after the tests' own length.
  initial begin
    repeat (60000) @(posedge CLK);
    n_errors++;
    print_verdict();
  end

  initial begin
    repeat (8) @(posedge CLK);
    RST_N <= 1'b1;
    rd(8'h04, rv);
    chk(rv, 32'h00040000);
    rd(8'h00, rv);
    chk(rv, 32'h0);
    rd(8'h08, rv);
    chk(rv, 32'h0);
    rd(8'h0C, rv);
    chk(rv, 32'h0);
    meas(256, 32, 32, 32);
    for (int i = 0; i < 5; i++) begin
      wr(8'h00, 32'h1000 | (i << 8) | i);
      rd(8'h00, rv);
      chk(rv, 32'h1000 | (i << 8) | i);
      meas(256, 32, 32 >> i, 32 >> i);
    end
    wr(8'h00, 32'h1005);
    rd(8'h00, rv);
    chk(rv, 32'h1004);
    wr(8'h00, 32'h0101);
    meas(256, 32, 16, 8);
    wr(8'h00, 32'h0);
    wr(8'h04, 32'h00040004);
    repeat (8000) @(posedge CLK);
    wr(8'h08, 32'h1);
    meas(256, 128, 128, 128);
    chk(32'(PLL_ON), 32'h1);
    wr(8'h08, 32'h0);
    rd(8'h08, rv);
    chk(rv, 32'h0);
    wr(8'h04, 32'h00040000);
    wr(8'h08, 32'h2);
    repeat (4001) @(posedge CLK);
    wr(8'h04, 32'h00040004);
    repeat (8000) @(posedge CLK);
    wr(8'h08, 32'h3);
    meas(256, 160, 160, 160);
    wr(8'h08, 32'h2);
    rd(8'h08, rv);
    chk(rv, 32'h2);
    wr(8'h04, 32'h00040000);
    meas(256, 32, 32, 32);
    wr(8'h18, 32'h5A);
    wr(8'h04, 32'h00041000);
    rd(8'h04, rv);
    chk(rv, 32'h00040000);
    wr(8'h18, 32'h0);
    wr(8'h10, 32'h33);
    wr(8'h14, 32'hC3);
    wr(8'h04, 32'h00241000);
    wr(8'h10, 32'h77);
    rd(8'h10, rv);
    chk(rv, 32'h0);
    chk(32'(PM_DATA_OUT), 32'h33);
    rd(8'h14, rv);
    chk(rv, 32'h0);
    chk(32'(PM_OD_OUT), 32'hC3);
    wr(8'h04, 32'h00251201);
    t0 = $time;
    rd(8'h04, rv);
    chk(rv, 32'h00251202);
    for (int k = 0; k < 300 && rv[1] !== 1'b0; k++) rd(8'h04, rv);
    el = int'(($time - t0) / 25);
    chk(rv, 32'h00251200);
    chk(32'(el >= 320 && el <= 360), 32'h1);
    wr(8'h04, 32'h00271200);
    repeat (20) @(posedge CLK);
    rd(8'h04, rv);
    chk(rv, 32'h00271200);
    wr(8'h04, 32'h00231200);
    meas(320, 32, 32, 32);
    chk(32'(INT_OSC_ON), 32'h0);
    wr(8'h04, 32'h00231201);
    pulse_stop_or_wake(1'b0);
    repeat (3) @(posedge CLK);
    #1;
    chk(32'(CPU_RUN), 32'h1);
    repeat (400) @(posedge CLK);
    wr(8'h04, 32'h00231200);
    pulse_stop_or_wake(1'b0);
    repeat (4) @(posedge CLK);
    #1;
    chk(32'(CPU_RUN), 32'h0);
    chk(32'(EXT_OSC_ON), 32'h0);
    el = n_sys;
    repeat (100) @(posedge CLK);
    #1;
    chk(32'(n_sys - el), 32'h0);
    pulse_stop_or_wake(1'b1);
    t0 = $time;
    for (int k = 0; k < 1000 && CPU_RUN !== 1'b1; k++) begin
      @(posedge CLK);
      #1;
    end
    el = int'(($time - t0) / 25);
    chk(32'(el >= 320 && el <= 380), 32'h1);
    meas(320, 32, 32, 32);
    print_verdict();
  end
endmodule
`default_nettype wire
